/* pkg/hart_bridge_pkg.sv */
`default_nettype none
package hart_bridge_pkg;
   localparam int          NUM_CHANNELS       = 2;
   localparam logic [7:0]  CMD_READ_ID_SHORT  = 8'h00;
   localparam logic [7:0]  CMD_READ_PV        = 8'h01;
   localparam logic [7:0]  CMD_READ_CURRENT   = 8'h02;
   localparam logic [7:0]  CMD_READ_DYN_VARS  = 8'h03;
   localparam logic [7:0]  CMD_READ_ID_TAG    = 8'h0B;
   localparam logic [7:0]  CMD_READ_TAG       = 8'h0D;
   localparam logic [7:0]  CMD_WRITE_TAG      = 8'h12;
   localparam logic [7:0]  CMD_SET_UPPER      = 8'h24;
   localparam logic [7:0]  CMD_SET_LOWER      = 8'h25;
   localparam logic [7:0]  CMD_SELF_TEST      = 8'h29;
   localparam logic [7:0]  CMD_ZERO_PV        = 8'h2B;
   localparam logic [7:0]  CMD_BURST_MODE     = 8'h6D;
   localparam int          TONE_MARK_HZ       = 1200;
   localparam int          TONE_SPACE_HZ      = 2200;
   localparam int          REF_CLK_HZ         = 10000000;
   localparam int          MARK_HALF_CYC      = REF_CLK_HZ / (2 * TONE_MARK_HZ);
   localparam int          SPACE_HALF_CYC     = REF_CLK_HZ / (2 * TONE_SPACE_HZ);
   localparam int          RESP_TIMEOUT_MS    = 500;
   localparam int          RESP_TIMEOUT_CYC   = RESP_TIMEOUT_MS * (REF_CLK_HZ / 1000);
   localparam int          TIMER_W            = 23;
   localparam logic [7:0]  COMM_ERR_FLAG      = 8'h80;
   localparam int          CFG_CHANGED_BIT    = 6;
   localparam logic [7:0]  BYTE_RESET         = 8'h00;
   localparam logic [15:0] STATUS_RESET       = 16'h0000;
   typedef enum logic [2:0] {
      CH_IDLE  = 3'b000,
      CH_SEND  = 3'b001,
      CH_WAIT  = 3'b011,
      CH_RECV  = 3'b010,
      CH_REPLY = 3'b110
   } ch_state_t;
endpackage
`default_nettype wire

/* rtl/fsk_tone_gen.sv */
`default_nettype none
module fsk_tone_gen
   import hart_bridge_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic bit_value,
   output logic      tone
);
   // ==========================================================
   // Square tone, later shaped to a sine by the analog front end
   // Thirteen bits: the mark half period does not fit in twelve
   logic [12:0] count_r;
   logic [12:0] count_nxt;
   logic        tone_r;
   logic        tone_nxt;
   logic [12:0] half_len;

   always_comb begin
      half_len  = bit_value ? 13'(MARK_HALF_CYC) : 13'(SPACE_HALF_CYC);
      count_nxt = count_r;
      tone_nxt  = tone_r;
      if (!enable) begin
         count_nxt = 13'h0000;
         tone_nxt  = 1'b0;
      end else if (count_r >= half_len - 13'h0001) begin
         count_nxt = 13'h0000;
         tone_nxt  = ~tone_r;
      end else begin
         count_nxt = count_r + 13'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count_r <= 13'h0000;
         tone_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tone_r  <= tone_nxt;
      end
   end

   assign tone = tone_r;
endmodule
`default_nettype wire

/* rtl/hart_master_channel_bridge.sv */
// Function
// - Two channels, one slave field device each, module is master.
// - Forward client command to device, return its reply the same path.
// - Link traffic is FSK at 1200 Hz and 2200 Hz, zero mean.
// - Command 0 alone may use the short frame address form.
// - Command 109 switches burst mode on or off.
// - In burst mode the slave repeats responses until burst is switched off.
// - Commands may carry no data; responses always carry data and status; the bridge takes in only the 16 status bits.
// - Check response status before treating the response as valid.
// - Evaluate the two status bytes and pass result on as diagnostics.
// - Raise diagnostic interrupt on changed parameters when enabled.
`default_nettype none
module hart_master_channel_bridge
   import hart_bridge_pkg::*;
#(
   parameter int TIMEOUT_CYC = RESP_TIMEOUT_CYC
)(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    diag_irq_enable,
   input  wire logic [NUM_CHANNELS-1:0] cmd_valid,
   input  wire logic [7:0]              cmd_code,
   input  wire logic                    cmd_short_addr,
   input  wire logic                    cmd_burst_on,
   output logic      [NUM_CHANNELS-1:0] cmd_ready,
   output logic      [NUM_CHANNELS-1:0] cmd_reject,
   input  wire logic [NUM_CHANNELS-1:0] link_rx_valid,
   input  wire logic [NUM_CHANNELS-1:0] link_rx_bit,
   output logic      [NUM_CHANNELS-1:0] link_tx_tone,
   output logic      [NUM_CHANNELS-1:0] link_tx_active,
   output logic      [NUM_CHANNELS-1:0] rsp_valid,
   output logic      [NUM_CHANNELS-1:0] rsp_ok,
   output logic      [NUM_CHANNELS-1:0] rsp_timeout,
   output logic      [15:0]             rsp_status [NUM_CHANNELS],
   output logic      [NUM_CHANNELS-1:0] burst_active,
   output logic      [NUM_CHANNELS-1:0] diag_comm_err,
   output logic      [NUM_CHANNELS-1:0] diag_irq
);
   // ==========================================================
   // Link input synchronisers
   logic [NUM_CHANNELS-1:0] rxv_s1_r, rxv_s2_r, rxb_s1_r, rxb_s2_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rxv_s1_r <= '0;
         rxv_s2_r <= '0;
         rxb_s1_r <= '0;
         rxb_s2_r <= '0;
      end else begin
         rxv_s1_r <= link_rx_valid;
         rxv_s2_r <= rxv_s1_r;
         rxb_s1_r <= link_rx_bit;
         rxb_s2_r <= rxb_s1_r;
      end
   end

   // ==========================================================
   // Status and address evaluation helpers
   function automatic logic status_ok(input logic [15:0] st);
      status_ok = (st[15:8] & COMM_ERR_FLAG) == BYTE_RESET;
   endfunction

   function automatic logic addr_ok(input logic [7:0] code,
                                    input logic       short_addr);
      addr_ok = !short_addr || (code == CMD_READ_ID_SHORT);
   endfunction

   // ==========================================================
   // Per-channel transaction engine
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_ch
         ch_state_t          state_r, state_nxt;
         logic [7:0]         shift_r, shift_nxt;
         logic [3:0]         bitcnt_r, bitcnt_nxt;
         logic [15:0]        stat_r, stat_nxt;
         logic [TIMER_W-1:0] timer_r, timer_nxt;
         logic               burst_r, burst_nxt;
         logic               ready_r, ready_nxt;
         logic               reject_r, reject_nxt;
         logic               rvalid_r, rvalid_nxt;
         logic               rok_r, rok_nxt;
         logic               rto_r, rto_nxt;
         logic               cerr_r, cerr_nxt;
         logic               irq_r, irq_nxt;
         logic               tone_w;

         fsk_tone_gen u_tone (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .enable    (state_r == CH_SEND),
            .bit_value (shift_r[0]),
            .tone      (tone_w)
         );

         always_comb begin
            state_nxt  = state_r;
            shift_nxt  = shift_r;
            bitcnt_nxt = bitcnt_r;
            stat_nxt   = stat_r;
            timer_nxt  = timer_r;
            burst_nxt  = burst_r;
            ready_nxt  = 1'b0;
            reject_nxt = 1'b0;
            rvalid_nxt = 1'b0;
            rok_nxt    = 1'b0;
            rto_nxt    = 1'b0;
            cerr_nxt   = cerr_r;
            irq_nxt    = 1'b0;
            case (state_r)
               CH_IDLE: begin
                  ready_nxt = 1'b1;
                  if (cmd_valid[ch] && ready_r) begin
                     ready_nxt = 1'b0;
                     if (!addr_ok(cmd_code, cmd_short_addr)) begin
                        reject_nxt = 1'b1;
                     end else begin
                        shift_nxt  = cmd_code;
                        bitcnt_nxt = 4'h0;
                        timer_nxt  = '0;
                        if (cmd_code == CMD_BURST_MODE) begin
                           burst_nxt = cmd_burst_on;
                        end
                        state_nxt = CH_SEND;
                     end
                  end else if (burst_r && rxv_s2_r[ch]) begin
                     // First status bit comes with the opening valid
                     ready_nxt  = 1'b0;
                     stat_nxt   = {stat_r[14:0], rxb_s2_r[ch]};
                     bitcnt_nxt = 4'h1;
                     timer_nxt  = '0;
                     state_nxt  = CH_RECV;
                  end
               end
               CH_SEND: begin
                  // One code bit per full mark period (two mark half periods), plain framing
                  if (timer_r >= TIMER_W'(MARK_HALF_CYC * 2 - 1)) begin
                     timer_nxt  = '0;
                     shift_nxt  = {1'b0, shift_r[7:1]};
                     bitcnt_nxt = bitcnt_r + 4'h1;
                     if (bitcnt_r == 4'h7) begin
                        state_nxt = CH_WAIT;
                     end
                  end else begin
                     timer_nxt = timer_r + TIMER_W'(1);
                  end
               end
               CH_WAIT: begin
                  timer_nxt = timer_r + TIMER_W'(1);
                  if (rxv_s2_r[ch]) begin
                     stat_nxt   = {stat_r[14:0], rxb_s2_r[ch]};
                     bitcnt_nxt = 4'h1;
                     timer_nxt  = '0;
                     state_nxt  = CH_RECV;
                  end else if (timer_r >= TIMER_W'(TIMEOUT_CYC - 1)) begin
                     rvalid_nxt = 1'b1;
                     rto_nxt    = 1'b1;
                     state_nxt  = CH_IDLE;
                  end
               end
               CH_RECV: begin
                  timer_nxt = timer_r + TIMER_W'(1);
                  if (rxv_s2_r[ch]) begin
                     stat_nxt   = {stat_r[14:0], rxb_s2_r[ch]};
                     bitcnt_nxt = bitcnt_r + 4'h1;
                     if (bitcnt_r == 4'hF) begin
                        state_nxt = CH_REPLY;
                     end
                  end else if (timer_r >= TIMER_W'(TIMEOUT_CYC - 1)) begin
                     rvalid_nxt = 1'b1;
                     rto_nxt    = 1'b1;
                     state_nxt  = CH_IDLE;
                  end
               end
               CH_REPLY: begin
                  rvalid_nxt = 1'b1;
                  rok_nxt    = status_ok(stat_r);
                  cerr_nxt   = !status_ok(stat_r);
                  irq_nxt    = diag_irq_enable &&
                               stat_r[CFG_CHANGED_BIT];
                  state_nxt  = CH_IDLE;
               end
               default: state_nxt = CH_IDLE;
            endcase
         end

         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               state_r  <= CH_IDLE;
               shift_r  <= BYTE_RESET;
               bitcnt_r <= 4'h0;
               stat_r   <= STATUS_RESET;
               timer_r  <= '0;
               burst_r  <= 1'b0;
               ready_r  <= 1'b0;
               reject_r <= 1'b0;
               rvalid_r <= 1'b0;
               rok_r    <= 1'b0;
               rto_r    <= 1'b0;
               cerr_r   <= 1'b0;
               irq_r    <= 1'b0;
            end else begin
               state_r  <= state_nxt;
               shift_r  <= shift_nxt;
               bitcnt_r <= bitcnt_nxt;
               stat_r   <= stat_nxt;
               timer_r  <= timer_nxt;
               burst_r  <= burst_nxt;
               ready_r  <= ready_nxt;
               reject_r <= reject_nxt;
               rvalid_r <= rvalid_nxt;
               rok_r    <= rok_nxt;
               rto_r    <= rto_nxt;
               cerr_r   <= cerr_nxt;
               irq_r    <= irq_nxt;
            end
         end

         logic tone_q_r;
         logic act_q_r;
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               tone_q_r <= 1'b0;
               act_q_r  <= 1'b0;
            end else begin
               tone_q_r <= tone_w;
               act_q_r  <= (state_r == CH_SEND);
            end
         end

         assign cmd_ready[ch]      = ready_r;
         assign cmd_reject[ch]     = reject_r;
         assign link_tx_tone[ch]   = tone_q_r;
         assign link_tx_active[ch] = act_q_r;
         assign rsp_valid[ch]      = rvalid_r;
         assign rsp_ok[ch]         = rok_r;
         assign rsp_timeout[ch]    = rto_r;
         assign rsp_status[ch]     = stat_r;
         assign burst_active[ch]   = burst_r;
         assign diag_comm_err[ch]  = cerr_r;
         assign diag_irq[ch]       = irq_r;
      end
   endgenerate
endmodule
`default_nettype wire

/* testbench/hart_bridge_chk.sv */
`default_nettype none
// ==========================================================
// Port checker
module hart_bridge_chk
   import hart_bridge_pkg::*;
#(
   parameter int TIMEOUT_CYC = RESP_TIMEOUT_CYC
)(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        diag_irq_enable,
   input wire logic [1:0]  cmd_valid,
   input wire logic [7:0]  cmd_code,
   input wire logic        cmd_short_addr,
   input wire logic        cmd_burst_on,
   input wire logic [1:0]  cmd_ready,
   input wire logic [1:0]  cmd_reject,
   input wire logic [1:0]  link_rx_valid,
   input wire logic [1:0]  link_rx_bit,
   input wire logic [1:0]  link_tx_tone,
   input wire logic [1:0]  link_tx_active,
   input wire logic [1:0]  rsp_valid,
   input wire logic [1:0]  rsp_ok,
   input wire logic [1:0]  rsp_timeout,
   input wire logic [15:0] rsp_status [2],
   input wire logic [1:0]  burst_active,
   input wire logic [1:0]  diag_comm_err,
   input wire logic [1:0]  diag_irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_reject;
      cmd_valid[0] && cmd_ready[0] && cmd_short_addr &&
      cmd_code != CMD_READ_ID_SHORT |=> cmd_reject[0];
   endproperty
   a_reject: assert property (p_reject) else $error("no refusal");
   property p_take;
      cmd_valid[0] && cmd_ready[0] |=> !cmd_ready[0];
   endproperty
   a_take: assert property (p_take) else $error("still ready");
   property p_send;
      cmd_valid[0] && cmd_ready[0] && !cmd_short_addr
      |=> ##[1:2] link_tx_active[0];
   endproperty
   a_send: assert property (p_send) else $error("no send");
   property p_busy;
      link_tx_active[1] |-> !cmd_ready[1];
   endproperty
   a_busy: assert property (p_busy) else $error("ready in send");
   property p_pulse;
      rsp_valid[0] |=> !rsp_valid[0];
   endproperty
   a_pulse: assert property (p_pulse) else $error("long rsp");
   property p_ok;
      rsp_valid[0] && rsp_ok[0] |-> !rsp_status[0][15] && !rsp_timeout[0];
   endproperty
   a_ok: assert property (p_ok) else $error("bad status ok");
   property p_comm;
      rsp_valid[0] && !rsp_timeout[0] |->
         diag_comm_err[0] == rsp_status[0][15];
   endproperty
   a_comm: assert property (p_comm) else $error("comm flag");
   property p_irq;
      diag_irq[0] |-> $past(diag_irq_enable) && rsp_status[0][6];
   endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
   property p_to;
      rsp_valid[1] && rsp_timeout[1] |-> !rsp_ok[1] ##[1:2] cmd_ready[1];
   endproperty
   a_to: assert property (p_to) else $error("timeout end");
   c_ok: cover property (rsp_valid[0] && rsp_ok[0]);
   c_to: cover property (rsp_valid[1] && rsp_timeout[1]);
   c_rej: cover property (cmd_reject[0]);
endmodule
bind hart_master_channel_bridge hart_bridge_chk
   #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.*);
`default_nettype wire

/* testbench/hart_slave_model.sv */
`default_nettype none
// ==========================================================
// Field device: status reply after each command when answer is set, or on burst_go
module hart_slave_model (
   input  wire logic        ref_clk,
   input  wire logic        tx_active,
   input  wire logic        answer,
   input  wire logic [7:0]  delay,
   input  wire logic [15:0] status,
   input  wire logic        burst_go,
   output logic             rx_valid,
   output logic             rx_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_r = 1'h0;
   logic go;
   task automatic reply();
      repeat (delay) @(negedge ref_clk);
      for (int i = 15; i >= 0; i--) begin
         rx_valid = 1'h1;
         rx_bit = status[i];
         @(negedge ref_clk);
      end
      rx_valid = 1'h0;
   endtask
   initial begin
      rx_valid = 1'h0;
      rx_bit = 1'h0;
      forever begin
         // Decide on the rising edge, drive on the falling one
         @(posedge ref_clk);
         go = burst_go;
         if (last_r && !tx_active && answer) go = 1'h1;
         last_r = tx_active;
         @(negedge ref_clk);
         rx_bit = ~rx_bit;
         // A command, read or write, is answered with its status pair only when answer is set; burst_go also starts one
         if (go) reply();
      end
   end
endmodule
`default_nettype wire

/* testbench/hart_master_channel_bridge_tb.sv */
`default_nettype none
// ==========================================================
// Testbench
module hart_master_channel_bridge_tb;
   import hart_bridge_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        diag_irq_enable = 1'h1;
   logic        cmd_short_addr = 1'h0;
   logic        cmd_burst_on = 1'h0;
   logic [7:0]  cmd_code = 8'h00;
   logic [1:0]  cmd_valid = 2'h0;
   logic [1:0]  burst_go = 2'h0;
   logic [15:0] dev_status = 16'h0040;
   logic [1:0]  cmd_ready, cmd_reject, link_tx_tone, link_tx_active;
   logic [1:0]  rsp_valid, rsp_ok, rsp_timeout, burst_active;
   logic [1:0]  diag_comm_err, diag_irq;
   logic [15:0] rsp_status [2];
   wire  [1:0]  link_rx_valid, link_rx_bit;
   int          errors = 0;
   int          checked = 0;
   hart_master_channel_bridge #(.TIMEOUT_CYC(200)) DUT (.*);
   for (genvar c = 0; c < 2; c++) begin : g_dev
      hart_slave_model u_dev (
         .ref_clk   (ref_clk),
         .tx_active (link_tx_active[c]),
         .answer    (c == 0),
         .delay     (8'h05),
         .status    (dev_status),
         .burst_go  (burst_go[c]),
         .rx_valid  (link_rx_valid[c]),
         .rx_bit    (link_rx_bit[c])
      );
   end
   initial forever #50 ref_clk = ~ref_clk;
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_rsp(int ch, int lim);
      int n;
      n = 0;
      while (rsp_valid[ch] !== 1'h1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      cmp("rsp_valid", 16'h0001, 16'(rsp_valid[ch]));
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Length of the first full tone half period seen on channel 0
   task automatic tone_run(output int n);
      logic t;
      for (int k = 0; k < 2; k++) begin
         t = link_tx_tone[0];
         n = 0;
         while (link_tx_tone[0] === t && n < 5000) begin
            @(negedge ref_clk);
            n++;
         end
      end
   endtask
   // Short address with a nonzero code is refused, nothing is sent
   task automatic t_reject();
      logic seen;
      seen = 1'h0;
      repeat (4) @(negedge ref_clk);
      cmp("ready", 16'h0003, 16'(cmd_ready));
      cmd_short_addr = 1'h1;
      cmd_code = CMD_READ_PV;
      cmd_valid = 2'h1;
      @(negedge ref_clk);
      cmd_valid = 2'h0;
      repeat (3) begin
         seen |= cmd_reject[0];
         @(negedge ref_clk);
      end
      cmp("reject", 16'h0001, 16'(seen));
      cmp("tx_active", 16'h0000, 16'(link_tx_active));
   endtask
   // Burst on to channel 0, off to channel 1; only channel 0 answers
   task automatic t_burst_cmd();
      int n;
      repeat (3) @(negedge ref_clk);
      cmd_short_addr = 1'h0;
      cmd_code = CMD_BURST_MODE;
      cmd_burst_on = 1'h1;
      cmd_valid = 2'h1;
      @(negedge ref_clk);
      cmd_burst_on = 1'h0;
      cmd_valid = 2'h2;
      @(negedge ref_clk);
      cmd_valid = 2'h3;
      cmd_short_addr = 1'h1;
      cmd_code = CMD_READ_PV;
      repeat (3) @(negedge ref_clk);
      cmd_valid = 2'h0;
      cmp("ready", 16'h0000, 16'(cmd_ready));
      cmp("reject", 16'h0000, 16'(cmd_reject));
      cmp("tx_active", 16'h0003, 16'(link_tx_active));
      tone_run(n);
      cmp("mark_half", 16'h0001, 16'(n >= MARK_HALF_CYC - 1 &&
          n <= MARK_HALF_CYC + 1));
      repeat (1000) @(negedge ref_clk);
      tone_run(n);
      cmp("space_half", 16'h0001, 16'(n >= SPACE_HALF_CYC - 1 &&
          n <= SPACE_HALF_CYC + 1));
      wait_rsp(0, 70000);
      cmp("rsp_ok", 16'h0001, 16'(rsp_ok[0]));
      cmp("status", 16'h0040, rsp_status[0]);
      cmp("irq", 16'h0001, 16'(diag_irq[0]));
      cmp("comm_err", 16'h0000, 16'(diag_comm_err[0]));
      repeat (2) @(negedge ref_clk);
      cmp("burst", 16'h0001, 16'(burst_active[0]));
      wait_rsp(1, 400);
      cmp("timeout", 16'h0001, 16'(rsp_timeout[1]));
      cmp("rsp_ok1", 16'h0000, 16'(rsp_ok[1]));
      cmp("burst1", 16'h0000, 16'(burst_active[1]));
   endtask
   // Unsolicited burst frame with a comm error, interrupts disabled
   task automatic t_burst_stream();
      repeat (3) @(negedge ref_clk);
      dev_status = 16'h8040;
      diag_irq_enable = 1'h0;
      burst_go = 2'h1;
      @(negedge ref_clk);
      burst_go = 2'h0;
      wait_rsp(0, 100);
      cmp("rsp_ok", 16'h0000, 16'(rsp_ok[0]));
      cmp("status", 16'h8040, rsp_status[0]);
      cmp("comm_err", 16'h0001, 16'(diag_comm_err[0]));
      cmp("irq", 16'h0000, 16'(diag_irq[0]));
   endtask
   initial begin
      repeat (90000) @(negedge ref_clk);
      errors++;
      final_report();
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      rst_n = 1'h1;
      t_reject();
      t_burst_cmd();
      t_burst_stream();
      final_report();
   end
endmodule
`default_nettype wire
